// file: inc/lrc_pkg.sv
/*
 * Shared constants, types and decode for the line interface reset and
 * line configuration register bank.
 * Assumes one system clock and a word-aligned register bus.
 */
package lrc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_LINE_MODE         = 6'h00;
	localparam logic [5:0] IDX_COMMON_CTRL_THREE = 6'h02;
	localparam logic [5:0] IDX_LINE_CONFIG_A     = 6'h03;
	localparam logic [5:0] IDX_LINE_CONFIG_B     = 6'h04;
	localparam logic [5:0] IDX_LINE_STATUS       = 6'h06;

	// Value of every writeable register after reset
	localparam logic [7:0] REG_RESET = 8'h00;

	// Field positions in line mode and common control three
	localparam int BIT_E1_T1_SELECT   = 7;
	localparam int BIT_TX_ALL_ONES_N  = 7;
	localparam int BIT_LINE_IF_RESET  = 2;

	// Field positions in line config A
	localparam int CFGA_BUILDOUT_HI = 7;
	localparam int CFGA_BUILDOUT_LO = 5;
	localparam int CFGA_EQ_GAIN_LIM = 4;
	localparam int CFGA_JA_PLACE    = 3;
	localparam int CFGA_JA_DEPTH    = 2;
	localparam int CFGA_JA_DISABLE  = 1;
	localparam int CFGA_TX_PWR_DOWN = 0;

	// Field positions in line config B
	localparam int CFGB_BP_CLK_HI  = 7;
	localparam int CFGB_BP_CLK_LO  = 6;
	localparam int CFGB_MON_HI     = 5;
	localparam int CFGB_MON_LO     = 4;
	localparam int CFGB_RX_SYNC    = 3;
	localparam int CFGB_TX_SYNC    = 2;
	localparam int CFGB_RX_TERM_HI = 1;
	localparam int CFGB_RX_TERM_LO = 0;

	// Field positions in line status
	localparam int STAT_LINE_IF_RESET_BIT_SEEN = 0;
	localparam int STAT_ALL_ONES   = 1;
	localparam int STAT_TX_OFF     = 2;
	localparam int STAT_JA_IN_TX   = 3;

	// Decoded figures
	localparam logic [7:0]  JA_BITS_DEEP    = 8'h80;
	localparam logic [7:0]  JA_BITS_SHALLOW = 8'h20;
	localparam logic [14:0] BP_KHZ_16384    = 15'h4000;
	localparam logic [14:0] BP_KHZ_8192     = 15'h2000;
	localparam logic [14:0] BP_KHZ_4096     = 15'h1000;
	localparam logic [14:0] BP_KHZ_2048     = 15'h0800;
	localparam logic [11:0] SYNC_KHZ_E1     = 12'h800;
	localparam logic [11:0] SYNC_KHZ_T1     = 12'h608;

	// Transmitter mode, Gray coded along off, ones, data
	typedef enum logic [1:0] {
		TXM_OFF  = 2'b00,
		TXM_ONES = 2'b01,
		TXM_DATA = 2'b11,
		TXM_SYNC = 2'b10
	} lrc_tx_mode_t;

	// Decoded line settings for the analog and clock blocks
	typedef struct packed {
		logic [2:0]  buildout;  // Pulse shape code
		logic [5:0]  rxSensDb;  // Sensitivity, minus dB
		logic        jaInRx;    // Attenuator in receive path
		logic        jaInTx;    // Attenuator in transmit path
		logic [7:0]  jaBits;    // Elastic depth, 0 when bypassed
		logic [14:0] bpClkKhz;  // Backplane clock rate
		logic [5:0]  monGainDb; // Monitor gain boost
		logic        rxSyncEn;  // Receiver takes sync signal
		logic        txSyncEn;  // Transmitter sends sync signal
		logic [11:0] syncKhz;   // Sync signal rate, kHz
		logic [6:0]  rxTermOhm; // Termination, 0 when off
		logic        txPwrDown; // Transmitter powered down
	} lrc_line_cfg_t;

	// Decode the two config registers and the line standard
	function automatic lrc_line_cfg_t lrc_decode(
		input logic [7:0] a, input logic [7:0] b, input logic t1);
		lrc_line_cfg_t c;
		c.buildout = a[CFGA_BUILDOUT_HI:CFGA_BUILDOUT_LO];
		case ({a[CFGA_EQ_GAIN_LIM], t1})
			2'b00:   c.rxSensDb = 6'h0c;
			2'b10:   c.rxSensDb = 6'h2b;
			2'b11:   c.rxSensDb = 6'h1e;
			default: c.rxSensDb = 6'h24;
		endcase
		c.jaInRx = !a[CFGA_JA_DISABLE] && !a[CFGA_JA_PLACE];
		c.jaInTx = !a[CFGA_JA_DISABLE] && a[CFGA_JA_PLACE];
		c.jaBits = a[CFGA_JA_DISABLE] ? 8'h00 :
			(a[CFGA_JA_DEPTH] ? JA_BITS_SHALLOW : JA_BITS_DEEP);
		case (b[CFGB_BP_CLK_HI:CFGB_BP_CLK_LO])
			2'b00:   c.bpClkKhz = BP_KHZ_16384;
			2'b01:   c.bpClkKhz = BP_KHZ_8192;
			2'b10:   c.bpClkKhz = BP_KHZ_4096;
			default: c.bpClkKhz = BP_KHZ_2048;
		endcase
		case (b[CFGB_MON_HI:CFGB_MON_LO])
			2'b00:   c.monGainDb = 6'h00;
			2'b01:   c.monGainDb = 6'h14;
			2'b10:   c.monGainDb = 6'h1a;
			default: c.monGainDb = 6'h20;
		endcase
		c.rxSyncEn = b[CFGB_RX_SYNC];
		c.txSyncEn = b[CFGB_TX_SYNC];
		c.syncKhz  = t1 ? SYNC_KHZ_T1 : SYNC_KHZ_E1;
		case (b[CFGB_RX_TERM_HI:CFGB_RX_TERM_LO])
			2'b00:   c.rxTermOhm = 7'h00;
			2'b01:   c.rxTermOhm = 7'h78;
			2'b10:   c.rxTermOhm = 7'h64;
			default: c.rxTermOhm = 7'h4b;
		endcase
		c.txPwrDown = a[CFGA_TX_PWR_DOWN];
		return c;
	endfunction : lrc_decode

	// Decoded settings for all-zero registers
	localparam lrc_line_cfg_t CFG_RESET =
		lrc_decode(REG_RESET, REG_RESET, 1'b0);

endpackage : lrc_pkg

// file: core/lrc_line_tx.sv
/*
 * Line output stage: picks power-down, all ones, sync signal or data
 * and drives the two line rails with an output enable.
 * Assumes the bit strobe and data come from logic on clk_sys.
 */
`timescale 1ns/1ps
module lrc_line_tx (
	// Clock, reset, enable
	input  wire logic clk_sys,
	input  wire logic lineRst,
	input  wire logic ce,
	// Mode controls
	input  wire logic powerDown,
	input  wire logic allOnes,
	input  wire logic syncEn,
	// Transmit data
	input  wire logic bitStrobe,
	input  wire logic dataPos,
	input  wire logic dataNeg,
	// Line rails
	output logic      linePos,
	output logic      lineNeg,
	output logic      lineOe
);
	import lrc_pkg::*;

	lrc_tx_mode_t mode;      // Current mode
	lrc_tx_mode_t next_mode; // Mode for the next cycle
	logic         markPhase; // Alternating mark polarity

	// Power-down first, then all ones, then sync signal
	always_comb begin
		if (powerDown)
			next_mode = TXM_OFF;
		else if (allOnes)
			next_mode = TXM_ONES;
		else if (syncEn)
			next_mode = TXM_SYNC;
		else
			next_mode = TXM_DATA;
	end

	// Mode register; reset leaves the line sending ones
	always_ff @(posedge clk_sys) begin
		if (lineRst)
			mode <= TXM_ONES;
		else if (ce)
			mode <= next_mode;
	end

	// Mark polarity flips with every all-ones mark sent
	always_ff @(posedge clk_sys) begin
		if (lineRst)
			markPhase <= 1'b0;
		else if (ce && bitStrobe && next_mode == TXM_ONES)
			markPhase <= !markPhase;
	end

	// Rail drive and enable
	always_ff @(posedge clk_sys) begin
		if (lineRst) begin
			linePos <= 1'b0;
			lineNeg <= 1'b0;
			lineOe  <= 1'b1;
		end else if (ce) begin
			lineOe <= (next_mode != TXM_OFF);
			case (next_mode)
				TXM_OFF: begin
					linePos <= 1'b0;
					lineNeg <= 1'b0;
				end
				TXM_ONES: if (bitStrobe) begin
					linePos <= !markPhase;
					lineNeg <= markPhase;
				end
				TXM_SYNC: if (bitStrobe) begin
					linePos <= !linePos;
					lineNeg <= 1'b0;
				end
				TXM_DATA: if (bitStrobe) begin
					linePos <= dataPos;
					lineNeg <= dataNeg;
				end
				default: begin
					linePos <= 1'b0;
					lineNeg <= 1'b0;
				end
			endcase
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (lineRst);

	property p_tx_ones;
		ce && bitStrobe && next_mode == TXM_ONES |=>
			linePos == !$past(markPhase) &&
			lineNeg == $past(markPhase);
	endproperty
	a_tx_ones: assert property (p_tx_ones)
		else $error("all ones marks do not alternate");

	property p_tx_data;
		ce && bitStrobe && !powerDown && !allOnes && !syncEn |=>
			linePos == $past(dataPos) && lineNeg == $past(dataNeg);
	endproperty
	a_tx_data: assert property (p_tx_data)
		else $error("data not passed to line");

	property p_tx_sync;
		ce && bitStrobe && next_mode == TXM_SYNC |=>
			linePos != $past(linePos) && !lineNeg;
	endproperty
	a_tx_sync: assert property (p_tx_sync)
		else $error("sync signal not toggling");

	property p_tx_off;
		ce && powerDown |=> !lineOe && !linePos && !lineNeg;
	endproperty
	a_tx_off: assert property (p_tx_off)
		else $error("line driven while powered down");

endmodule : lrc_line_tx

// file: core/lrc_reset_line_cfg.sv
/*
 * Reset handling and line configuration registers of a single
 * channel line interface, with an Avalon-MM slave and a line stage.
 * Assumes clk_sys at 20 MHz; the hardware reset pin is asynchronous.
 */
//
// How it works
// - Power-up loads all writeable registers with zero
// - Power-up clears status and information registers
// - All-ones bit zero sends unframed all ones
// - Low hardware reset pin restores defaults anytime
// - Config A bits 7..5 select build-out
// - Gain limit with line standard sets sensitivity
// - Placement bit puts attenuator in rx or tx
// - Depth bit selects 128 or 32 bits
// - Two bits select backplane clock rate
// - Two bits select monitor gain boost
// - Receive sync bit accepts sync signal instead
// - Transmit sync bit sends sync signal instead
// - Two bits select receive termination
// - All-ones bit one transmits data normally
`timescale 1ns/1ps
module lrc_reset_line_cfg (
	// Clock, reset, enable
	input  wire logic                  clk_sys,
	input  wire logic                  sys_rst,
	input  wire logic                  ce,
	// Hardware reset pin, active low, asynchronous
	input  wire logic                  hwResetN,
	// Avalon-MM slave
	input  wire logic [7:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// Transmit data from the coder
	input  wire logic                  txBitStrobe,
	input  wire logic                  txDataPos,
	input  wire logic                  txDataNeg,
	// Line output rails
	output logic                       lineOutPos,
	output logic                       lineOutNeg,
	output logic                       lineOutOe,
	// Settings for the analog and clock blocks
	output lrc_pkg::lrc_line_cfg_t     lineCfg,
	output logic                       lineIfResetPulse
);
	import lrc_pkg::*;

	// Hardware reset synchroniser
	logic       hwRstMeta;  // First stage
	logic       hwRstSync;  // Second stage, low means reset
	logic       regClear;   // Any reset of the register bank

	// Register contents
	logic       e1T1Select; // Line standard, 1 is T1
	logic [7:0] commonCtrlThree;
	logic [7:0] lineConfigA;
	logic [7:0] lineConfigB;
	logic       lirstSeen;  // Sticky line reset event

	// Bus decode
	logic [5:0] busIdx;     // Word index of the access
	logic       busAligned; // Low address bits zero
	logic       wrEn;       // Write taking effect now
	logic       rdTake;     // Read being latched now
	logic [7:0] rdMux;      // Selected read value
	logic [7:0] statusWord; // Live status view
	logic       lirstPrev;  // Line reset bit, last cycle
	logic       lirstRise;  // Line reset bit went high

	// Two flops before the pin is used; only stage two is read
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			hwRstMeta <= 1'b0;
			hwRstSync <= 1'b0;
		end else if (ce) begin
			hwRstMeta <= hwResetN;
			hwRstSync <= hwRstMeta;
		end
	end

	// Power-up and the level-sensitive pin both clear the bank
	assign regClear = sys_rst || !hwRstSync;

	// Address decode shared by reads and writes
	assign busIdx     = avs_address[7:2];
	assign busAligned = (avs_address[1:0] == 2'b00);
	assign wrEn = ce && avs_write && !avs_waitrequest &&
		busAligned && avs_byteenable[0];
	assign rdTake = ce && avs_read && avs_waitrequest;

	// One wait cycle per access, then release
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			avs_waitrequest <= 1'b1;
		else if (ce)
			avs_waitrequest <= !((avs_read || avs_write) &&
				avs_waitrequest);
	end

	// Line standard select, held in line mode bit 7
	always_ff @(posedge clk_sys) begin
		if (regClear)
			e1T1Select <= REG_RESET[BIT_E1_T1_SELECT];
		else if (wrEn && busIdx == IDX_LINE_MODE)
			e1T1Select <= avs_writedata[BIT_E1_T1_SELECT];
	end

	// Common control three
	always_ff @(posedge clk_sys) begin
		if (regClear)
			commonCtrlThree <= REG_RESET;
		else if (wrEn && busIdx == IDX_COMMON_CTRL_THREE)
			commonCtrlThree <= avs_writedata[7:0];
	end

	// Line config A
	always_ff @(posedge clk_sys) begin
		if (regClear)
			lineConfigA <= REG_RESET;
		else if (wrEn && busIdx == IDX_LINE_CONFIG_A)
			lineConfigA <= avs_writedata[7:0];
	end

	// Line config B
	always_ff @(posedge clk_sys) begin
		if (regClear)
			lineConfigB <= REG_RESET;
		else if (wrEn && busIdx == IDX_LINE_CONFIG_B)
			lineConfigB <= avs_writedata[7:0];
	end

	// Edge detect on the line interface reset bit
	always_ff @(posedge clk_sys) begin
		if (regClear)
			lirstPrev <= 1'b0;
		else if (ce)
			lirstPrev <= commonCtrlThree[BIT_LINE_IF_RESET];
	end
	assign lirstRise = ce && !lirstPrev &&
		commonCtrlThree[BIT_LINE_IF_RESET];

	// Software sets the bit after programming; one pulse per rise
	always_ff @(posedge clk_sys) begin
		if (regClear)
			lineIfResetPulse <= 1'b0;
		else if (ce)
			lineIfResetPulse <= lirstRise;
	end

	// Sticky event; a new event beats a same-cycle clear
	always_ff @(posedge clk_sys) begin
		if (regClear)
			lirstSeen <= 1'b0;
		else if (lirstRise)
			lirstSeen <= 1'b1;
		else if (wrEn && busIdx == IDX_LINE_STATUS &&
			avs_writedata[STAT_LINE_IF_RESET_BIT_SEEN])
			lirstSeen <= 1'b0;
	end

	// Live status view; unused bits read zero
	always_comb begin
		statusWord = 8'h00;
		statusWord[STAT_LINE_IF_RESET_BIT_SEEN] = lirstSeen;
		statusWord[STAT_ALL_ONES] =
			!commonCtrlThree[BIT_TX_ALL_ONES_N];
		statusWord[STAT_TX_OFF] = lineConfigA[CFGA_TX_PWR_DOWN];
		statusWord[STAT_JA_IN_TX] = lineCfg.jaInTx;
	end

	// Read selection; unmapped or misaligned reads give zero
	always_comb begin
		rdMux = 8'h00;
		if (busAligned) begin
			case (busIdx)
				IDX_LINE_MODE:
					rdMux[BIT_E1_T1_SELECT] = e1T1Select;
				IDX_COMMON_CTRL_THREE: rdMux = commonCtrlThree;
				IDX_LINE_CONFIG_A:     rdMux = lineConfigA;
				IDX_LINE_CONFIG_B:     rdMux = lineConfigB;
				IDX_LINE_STATUS:       rdMux = statusWord;
				default:               rdMux = 8'h00;
			endcase
		end
	end

	// Read data latched on the wait cycle, stands when released
	always_ff @(posedge clk_sys) begin
		if (sys_rst)
			avs_readdata <= 32'h00000000;
		else if (rdTake)
			avs_readdata <= {24'h000000, rdMux};
	end

	// Decoded settings, registered for the outside blocks
	always_ff @(posedge clk_sys) begin
		if (regClear)
			lineCfg <= CFG_RESET;
		else if (ce)
			lineCfg <= lrc_decode(lineConfigA, lineConfigB,
				e1T1Select);
	end

	// Line output stage
	lrc_line_tx u_line_tx (
		.clk_sys   (clk_sys),
		.lineRst   (regClear),
		.ce        (ce),
		.powerDown (lineConfigA[CFGA_TX_PWR_DOWN]),
		.allOnes   (!commonCtrlThree[BIT_TX_ALL_ONES_N]),
		.syncEn    (lineConfigB[CFGB_TX_SYNC]),
		.bitStrobe (txBitStrobe),
		.dataPos   (txDataPos),
		.dataNeg   (txDataNeg),
		.linePos   (lineOutPos),
		.lineNeg   (lineOutNeg),
		.lineOe    (lineOutOe)
	);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// Write accepted to a register, then settings follow
	sequence s_wr_cfga;
		wrEn && busIdx == IDX_LINE_CONFIG_A;
	endsequence

	sequence s_cfg_follow;
		ce [*2];
	endsequence

	property p_pin_clear;
		!hwRstSync |=> lineConfigA == REG_RESET &&
			lineConfigB == REG_RESET &&
			commonCtrlThree == REG_RESET && !e1T1Select;
	endproperty
	a_pin_clear: assert property (p_pin_clear)
		else $error("hardware reset did not clear registers");

	property p_status_clear;
		!hwRstSync |=> !lirstSeen && !lineIfResetPulse;
	endproperty
	a_status_clear: assert property (p_status_clear)
		else $error("status not cleared by reset");

	property p_cfg_reset;
		!hwRstSync |=> lineCfg == CFG_RESET;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset)
		else $error("decoded settings not at reset value");

	property p_buildout;
		(s_wr_cfga ##0 s_cfg_follow) and (hwRstSync [*3]) |=>
			lineCfg.buildout == $past(avs_writedata[7:5], 2);
	endproperty
	a_buildout: assert property (p_buildout)
		else $error("build-out code not applied");

	property p_sens;
		ce && hwRstSync |=> lineCfg.rxSensDb ==
			($past(lineConfigA[CFGA_EQ_GAIN_LIM]) ?
			($past(e1T1Select) ? 6'h1e : 6'h2b) :
			($past(e1T1Select) ? 6'h24 : 6'h0c));
	endproperty
	a_sens: assert property (p_sens)
		else $error("wrong receive sensitivity");

	property p_ja_place;
		ce && hwRstSync && !lineConfigA[CFGA_JA_DISABLE] |=>
			lineCfg.jaInTx == $past(lineConfigA[CFGA_JA_PLACE]) &&
			lineCfg.jaInRx == !$past(lineConfigA[CFGA_JA_PLACE]);
	endproperty
	a_ja_place: assert property (p_ja_place)
		else $error("attenuator in wrong path");

	property p_ja_depth;
		ce && hwRstSync && !lineConfigA[CFGA_JA_DISABLE] |=>
			lineCfg.jaBits == ($past(lineConfigA[CFGA_JA_DEPTH]) ?
			8'h20 : 8'h80);
	endproperty
	a_ja_depth: assert property (p_ja_depth)
		else $error("attenuator depth wrong");

	property p_ja_bypass;
		ce && hwRstSync && lineConfigA[CFGA_JA_DISABLE] |=>
			lineCfg.jaBits == 8'h00 && !lineCfg.jaInRx &&
			!lineCfg.jaInTx;
	endproperty
	a_ja_bypass: assert property (p_ja_bypass)
		else $error("attenuator not bypassed");

	property p_bp_clk;
		ce && hwRstSync && lineConfigB[7:6] == 2'b11 |=>
			lineCfg.bpClkKhz == 15'h0800;
	endproperty
	a_bp_clk: assert property (p_bp_clk)
		else $error("backplane clock select wrong");

	property p_mon;
		ce && hwRstSync && lineConfigB[5:4] == 2'b10 |=>
			lineCfg.monGainDb == 6'h1a;
	endproperty
	a_mon: assert property (p_mon)
		else $error("monitor gain wrong");

	property p_rx_sync;
		ce && hwRstSync |=> lineCfg.rxSyncEn ==
			$past(lineConfigB[CFGB_RX_SYNC]) &&
			lineCfg.syncKhz == ($past(e1T1Select) ?
			12'h608 : 12'h800);
	endproperty
	a_rx_sync: assert property (p_rx_sync)
		else $error("receive sync select wrong");

	property p_term;
		ce && hwRstSync && lineConfigB[1:0] == 2'b01 |=>
			lineCfg.rxTermOhm == 7'h78;
	endproperty
	a_term: assert property (p_term)
		else $error("termination select wrong");

	property p_ones_pin;
		ce && hwRstSync && !commonCtrlThree[BIT_TX_ALL_ONES_N] &&
			!lineConfigA[CFGA_TX_PWR_DOWN] |=> lineOutOe;
	endproperty
	a_ones_pin: assert property (p_ones_pin)
		else $error("line not driven while sending ones");

endmodule : lrc_reset_line_cfg

// file: verification/lrc_reset_line_cfg_tb_top.sv
/*
 * Self-checking bench for the line interface reset and line config bank:
 * register defaults, field decode, line output modes, line reset pulse
 * and the hardware reset pin.
 * Assumes lrc_pkg and the design files are compiled first.
 */
`timescale 1ns/1ps
module lrc_reset_line_cfg_tb_top;
	import lrc_pkg::*;

	localparam int LIMIT = 4000; // Cycle ceiling for the whole run
	// Expected decode tables, indexed by the field value
	localparam logic [15:0] SENS [4] = '{16'h0c, 16'h24, 16'h2b, 16'h1e};
	localparam logic [15:0] BPK  [4] = '{16'h4000, 16'h2000, 16'h1000,
		16'h0800};
	localparam logic [15:0] MON  [4] = '{16'h00, 16'h14, 16'h1a, 16'h20};
	localparam logic [15:0] TERM [4] = '{16'h00, 16'h78, 16'h64, 16'h4b};
	// Config A values: build-out, gain limit and attenuator variety
	localparam logic [7:0]  CFGA [4] = '{8'h38, 8'h74, 8'hca, 8'he5};

	logic          clk_sys;         // System clock
	logic          sys_rst;         // Power-up reset
	logic          ce;              // Clock enable
	logic          hwResetN;        // Hardware reset pin
	logic [7:0]    avs_address;     // Bus address
	logic          avs_read;        // Bus read
	logic          avs_write;       // Bus write
	logic [31:0]   avs_writedata;   // Bus write data
	logic [3:0]    avs_byteenable;  // Bus lanes
	logic [31:0]   avs_readdata;    // Bus read data
	logic          avs_waitrequest; // Bus wait
	logic          txBitStrobe;     // Line bit strobe
	logic          txDataPos;       // Positive rail data
	logic          txDataNeg;       // Negative rail data
	logic          lineOutPos;      // Positive rail out
	logic          lineOutNeg;      // Negative rail out
	logic          lineOutOe;       // Rail drive enable
	lrc_line_cfg_t lineCfg;         // Decoded settings
	logic          lineIfResetPulse; // Line reset pulse
	int            fails;           // Mismatch count
	int            checked;         // Comparison count
	int            cyc;             // Cycle counter for the ceiling
	logic [31:0]   rd;              // Last read data

	lrc_reset_line_cfg lrc_reset_line_cfg_i (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .hwResetN(hwResetN),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .txBitStrobe(txBitStrobe),
		.txDataPos(txDataPos), .txDataNeg(txDataNeg),
		.lineOutPos(lineOutPos), .lineOutNeg(lineOutNeg),
		.lineOutOe(lineOutOe), .lineCfg(lineCfg),
		.lineIfResetPulse(lineIfResetPulse)
	);

	// Clock at 20 MHz
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Hang guard: a run past the ceiling counts as a mismatch
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			fails++;
			test_done();
		end
	end

	// Final counts and verdict
	task automatic test_done();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done

	// Compare register read data
	task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp_reg

	// Compare a decoded settings field
	task automatic cmp_fld(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp_fld

	// Compare a line pin
	task automatic cmp_pin(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp_pin

	// One bus transfer; held until waitrequest is seen low, however
	// long that takes; only the cycle ceiling ends a hung wait
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= {24'h0, d};
		avs_write     <= wr;
		avs_read      <= !wr;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask : bus

	// Read a register and compare with the expected byte
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		cmp_reg(rd, {24'h0, e});
	endtask : rd_chk

	// One line bit; returns once the rails show it
	task automatic strobe(input logic p, input logic n);
		@(posedge clk_sys);
		txBitStrobe <= 1'b1;
		txDataPos   <= p;
		txDataNeg   <= n;
		@(posedge clk_sys);
		txBitStrobe <= 1'b0;
		@(posedge clk_sys);
	endtask : strobe

	// Defaults after power-up, unmapped and misaligned places
	task automatic t_reset();
		rd_chk(8'h00, 8'h00);
		rd_chk(8'h08, 8'h00);
		rd_chk(8'h0c, 8'h00);
		rd_chk(8'h10, 8'h00);
		rd_chk(8'h18, 8'h02);
		bus(1'b1, 8'h14, 8'hff);
		rd_chk(8'h14, 8'h00);
		rd_chk(8'h0d, 8'h00);
		cmp_fld(16'(lineCfg.bpClkKhz), 16'h4000);
		$display("t_reset done");
	endtask : t_reset

	// Program both config registers and the line standard, then decode
	task automatic t_cfg();
		logic [7:0] a;
		logic [7:0] b;
		logic [1:0] i2;
		logic       t1;
		for (int i = 0; i < 4; i++) begin
			i2 = 2'(i);
			a  = CFGA[i];
			t1 = i2[0];
			b  = {i2, i2, i2[0], !i2[0], i2};
			bus(1'b1, 8'h00, {t1, 7'h00});
			bus(1'b1, 8'h0c, a);
			bus(1'b1, 8'h10, b);
			repeat (2) @(posedge clk_sys);
			rd_chk(8'h0c, a);
			rd_chk(8'h10, b);
			cmp_fld(16'(lineCfg.buildout), 16'(a[7:5]));
			cmp_fld(16'(lineCfg.rxSensDb), SENS[{a[4], t1}]);
			cmp_fld(16'(lineCfg.jaInRx), 16'(!a[1] && !a[3]));
			cmp_fld(16'(lineCfg.jaInTx), 16'(!a[1] && a[3]));
			cmp_fld(16'(lineCfg.jaBits),
				a[1] ? 16'h0 : (a[2] ? 16'h20 : 16'h80));
			cmp_fld(16'(lineCfg.bpClkKhz), BPK[b[7:6]]);
			cmp_fld(16'(lineCfg.monGainDb), MON[b[5:4]]);
			cmp_fld(16'(lineCfg.rxSyncEn), 16'(b[3]));
			cmp_fld(16'(lineCfg.txSyncEn), 16'(b[2]));
			cmp_fld(16'(lineCfg.syncKhz), t1 ? 16'd1544 : 16'd2048);
			cmp_fld(16'(lineCfg.rxTermOhm), TERM[b[1:0]]);
			cmp_fld(16'(lineCfg.txPwrDown), 16'(a[0]));
		end
		$display("t_cfg done");
	endtask : t_cfg

	// Line stage modes: power-down, all ones, data, sync signal
	task automatic t_line();
		logic first;
		strobe(1'b1, 1'b0);
		cmp_pin(lineOutOe, 1'b0);
		bus(1'b1, 8'h0c, 8'h00);
		bus(1'b1, 8'h10, 8'h00);
		bus(1'b1, 8'h08, 8'h00);
		strobe(1'b0, 1'b0);
		cmp_pin(lineOutOe, 1'b1);
		cmp_pin(lineOutPos ^ lineOutNeg, 1'b1);
		first = lineOutPos;
		strobe(1'b0, 1'b0);
		cmp_pin(lineOutPos, !first);
		bus(1'b1, 8'h08, 8'h80);
		strobe(1'b1, 1'b0);
		cmp_pin(lineOutPos, 1'b1);
		cmp_pin(lineOutNeg, 1'b0);
		strobe(1'b0, 1'b1);
		cmp_pin(lineOutPos, 1'b0);
		cmp_pin(lineOutNeg, 1'b1);
		bus(1'b1, 8'h10, 8'h04);
		strobe(1'b1, 1'b1);
		first = lineOutPos;
		cmp_pin(lineOutNeg, 1'b0);
		strobe(1'b1, 1'b1);
		cmp_pin(lineOutPos, !first);
		$display("t_line done");
	endtask : t_line

	// Software toggles the line reset bit after programming
	task automatic t_line_if_reset_bit();
		int seen;
		seen = 0;
		bus(1'b1, 8'h08, 8'h84);
		repeat (5) begin
			@(posedge clk_sys);
			if (lineIfResetPulse === 1'b1)
				seen++;
		end
		cmp_fld(16'(seen), 16'h1);
		rd_chk(8'h08, 8'h84);
		rd_chk(8'h18, 8'h01);
		// Clear the sticky event, then toggle again so it is set
		// when the hardware reset pin has to clear it
		bus(1'b1, 8'h18, 8'h01);
		rd_chk(8'h18, 8'h00);
		bus(1'b1, 8'h08, 8'h80);
		bus(1'b1, 8'h08, 8'h84);
		repeat (2) @(posedge clk_sys);
		rd_chk(8'h18, 8'h01);
		$display("t_line_if_reset_bit done");
	endtask : t_line_if_reset_bit

	// Hardware reset pin low in mid-run restores defaults
	task automatic t_hwrst();
		bus(1'b1, 8'h0c, 8'h55);
		@(posedge clk_sys);
		hwResetN <= 1'b0;
		repeat (6) @(posedge clk_sys);
		hwResetN <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd_chk(8'h0c, 8'h00);
		rd_chk(8'h10, 8'h00);
		rd_chk(8'h08, 8'h00);
		rd_chk(8'h18, 8'h02);
		rd_chk(8'h00, 8'h00);
		cmp_fld(16'(lineCfg.syncKhz), 16'd2048);
		cmp_fld(16'(lineCfg.txSyncEn), 16'h0);
		cmp_fld(16'(lineCfg.jaBits), 16'h80);
		$display("t_hwrst done");
	endtask : t_hwrst

	// Main sequence
	initial begin
		fails          = 0;
		checked        = 0;
		cyc            = 0;
		sys_rst        = 1'b1;
		ce             = 1'b1;
		hwResetN       = 1'b1;
		avs_address    = 8'h00;
		avs_read       = 1'b0;
		avs_write      = 1'b0;
		avs_writedata  = 32'h0;
		avs_byteenable = 4'hf;
		txBitStrobe    = 1'b0;
		txDataPos      = 1'b0;
		txDataNeg      = 1'b0;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		repeat (3) @(posedge clk_sys);
		t_reset();
		t_cfg();
		t_line();
		t_line_if_reset_bit();
		t_hwrst();
		test_done();
	end

endmodule : lrc_reset_line_cfg_tb_top
